// *** dma_arb_if.sv ***
// Request and grant signals between the transfer engine and its arbiter.
// Assumes both ends share one clock; the grant is combinational.
`timescale 1ns/1ps
interface dma_arb_if #(
  parameter int N  = 2,
  parameter int CW = 1
) ();
  logic [N-1:0]  req;
  logic          gnt_valid;
  logic [CW-1:0] gnt_idx;
  modport engine  (output req, input gnt_valid, input gnt_idx);
  modport arbiter (input req, output gnt_valid, output gnt_idx);
endinterface : dma_arb_if

// *** dma_channel_regs.sv ***
// Peripheral DMA controller: per-channel registers and transfer engine.
// Assumes AXI4-Lite masters and a memory port that answers with mem_ack.
`timescale 1ns/1ps
// What this block does
// - Pointer is loaded by software, then always names the next location.
// - Peripheral identifier is passed out on mem_pid with each item request and reads back at offset 0x04.
// - Item count sits in bits 15:0 and shows items still to move.
// - Count reaching zero with nonzero reload copies pointer reload in.
// - Count reaching zero with nonzero reload takes the reload count.
// - Count zero and reload zero means no more transfers.
// - The count reload register clears when the count reloads.
// - Writing one to command bit 8 clears the error and resumes.
// - Writing one to command bit 0 enables the channel.
// - Writing one to command bit 1 disables the channel.
// - Size field: byte, half-word, word; code three is reserved.
// - State bit 0 reads one while the channel is enabled.
// - Writing ones to the enable register sets mask bits 2, 1, 0.
// - Writing ones to the disable register clears mask bits 2, 1, 0.
// - Mask view register shows which sources are enabled.
// - Error status stays set until the error clear command.
// - Complete status is one when count and reload count are zero.
// - Reload-zero status is one while the reload count is zero.
// - Peripheral identifier width is a build parameter.
// - Each item advances the pointer by 1, 2 or 4 and counts down.
// - Lowest numbered requesting channel is served first.
// - A failed memory access sets the error flag and stops the channel.
module dma_channel_regs #(
  parameter int N_CH   = 2,
  parameter int PID_W  = 5,
  parameter int ADDR_W = 12
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ADDR_W-1:0]             awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [dma_pkg::DATA_W-1:0]    wdata,
  input  wire logic [dma_pkg::STRB_W-1:0]    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [ADDR_W-1:0]             araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [dma_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [N_CH-1:0]               periph_req,
  output logic      [N_CH-1:0]               periph_ack,
  output logic                               mem_req,
  output logic [dma_pkg::DATA_W-1:0]         mem_addr,
  output logic [dma_pkg::SIZE_W-1:0]         mem_size,
  output logic [PID_W-1:0]                   mem_pid,
  input  wire logic                          mem_ack,
  input  wire logic                          mem_err,
  output logic      [N_CH-1:0]               chan_irq
);
  import dma_pkg::*;

  localparam int CH_W = (N_CH > 1) ? $clog2(N_CH) : 1;
  localparam int SEL_W = ADDR_W - CH_STRIDE_LSB;

  typedef struct packed {
    logic [N_CH-1:0][DATA_W-1:0] mem_pointer;
    logic [N_CH-1:0][DATA_W-1:0] mem_pointer_reload;
    logic [N_CH-1:0][CNT_W-1:0]  item_count;
    logic [N_CH-1:0][CNT_W-1:0]  item_count_reload;
    logic [N_CH-1:0][PID_W-1:0]  peripheral_identifier;
    logic [N_CH-1:0][SIZE_W-1:0] size;
    logic [N_CH-1:0]             en;
    logic [N_CH-1:0]             err;
    logic [N_CH-1:0]             pack;
    xf_state_t                   xf;
    logic [CH_W-1:0]             cur;
    logic [DATA_W-1:0]           ma;
    logic [SIZE_W-1:0]           ms;
    logic [PID_W-1:0]            mp;
    logic                        aw_ok;
    logic                        w_ok;
    logic [ADDR_W-1:0]           awa;
    logic [DATA_W-1:0]           wd;
    logic [STRB_W-1:0]           ws;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [DATA_W-1:0]           rdata;
    logic [1:0]                  rresp;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  dma_arb_if #(.N(N_CH), .CW(CH_W)) arb ();

  logic [N_CH-1:0][NSRC-1:0] mask_w;
  logic [N_CH-1:0][NSRC-1:0] stat_w;
  logic [N_CH-1:0][NSRC-1:0] set_w;
  logic [N_CH-1:0][NSRC-1:0] clr_w;
  logic [DATA_W-1:0]         bm;
  logic [DATA_W-1:0]         wd_m;
  logic [DATA_W-1:0]         wv;
  logic [CH_W-1:0]           wch;
  logic [5:0]                woff;
  logic                      wr_go;
  logic                      wr_hit;
  logic [CH_W-1:0]           ach;
  logic [5:0]                aoff;
  logic                      ar_hit;
  logic [DATA_W-1:0]         stp;

  function automatic logic [DATA_W-1:0] step_of(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: step_of = STEP_BYTE;
      SIZE_HALF: step_of = STEP_HALF;
      SIZE_WORD: step_of = STEP_WORD;
      default:   step_of = '0;
    endcase
  endfunction : step_of

  // Command and enable/disable registers are write-only and read as zero.
  function automatic logic [DATA_W-1:0] rd_word(input logic [CH_W-1:0] c,
                                                input logic [5:0] o);
    case (o)
      OFF_MAR:  rd_word = s_r.mem_pointer[c];
      OFF_PSR:  rd_word = DATA_W'(s_r.peripheral_identifier[c]);
      OFF_TCR:  rd_word = DATA_W'(s_r.item_count[c]);
      OFF_MEM_POINTER_RELOAD: rd_word = s_r.mem_pointer_reload[c];
      OFF_ITEM_COUNT_RELOAD: rd_word = DATA_W'(s_r.item_count_reload[c]);
      OFF_MODE: rd_word = DATA_W'(s_r.size[c]);
      OFF_STAT: rd_word = DATA_W'(s_r.en[c]);
      OFF_IMR:  rd_word = DATA_W'(mask_w[c]);
      OFF_ISR:  rd_word = DATA_W'(stat_w[c]);
      default:  rd_word = '0;
    endcase
  endfunction : rd_word

  always_comb begin
    for (int b = 0; b < STRB_W; b++) begin
      bm[b*8 +: 8] = {8{s_r.ws[b]}};
    end
  end

  assign wd_m   = s_r.wd & bm;
  assign wch    = s_r.awa[CH_STRIDE_LSB +: CH_W];
  assign woff   = {s_r.awa[5:2], 2'h0};
  assign wr_go  = s_r.aw_ok && s_r.w_ok;
  assign wr_hit = (s_r.awa[ADDR_W-1:CH_STRIDE_LSB] < SEL_W'(N_CH))
                  && (woff <= OFF_ISR);
  // The read-back function looks at the whole register state, so a process
  // re-evaluates it where a continuous assignment would only see arguments.
  always_comb begin
    wv = (rd_word(wch, woff) & ~bm) | wd_m;
  end
  assign ach    = araddr[CH_STRIDE_LSB +: CH_W];
  assign aoff   = {araddr[5:2], 2'h0};
  assign ar_hit = (araddr[ADDR_W-1:CH_STRIDE_LSB] < SEL_W'(N_CH))
                  && (aoff <= OFF_ISR);
  assign stp    = step_of(s_r.ms);

  assign awready = !s_r.aw_ok && !s_r.bvalid;
  assign wready  = !s_r.w_ok && !s_r.bvalid;
  assign arready = !s_r.rvalid;

  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      arb.req[i] = (s_r.xf == XF_IDLE) && periph_req[i] && s_r.en[i]
                   && !s_r.err[i] && !s_r.pack[i]
                   && (s_r.item_count[i] != '0)
                   && (s_r.size[i] != SIZE_RSVD);
      set_w[i] = '0;
      clr_w[i] = '0;
      if (wr_go && wr_hit && (wch == CH_W'(i))) begin
        if (woff == OFF_IER) set_w[i] = wd_m[NSRC-1:0];
        if (woff == OFF_IDR) clr_w[i] = wd_m[NSRC-1:0];
      end
    end
  end

  dma_prio_arbiter #(.N(N_CH), .CW(CH_W)) u_arb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .a       (arb.arbiter)
  );

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_irq
      dma_irq_unit u_irq (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .en_set   (set_w[g]),
        .en_clr   (clr_w[g]),
        .err      (s_r.err[g]),
        .cnt_zero (s_r.item_count[g] == '0),
        .rld_zero (s_r.item_count_reload[g] == '0),
        .mask     (mask_w[g]),
        .status   (stat_w[g]),
        .irq      (chan_irq[g])
      );
    end
  endgenerate

  always_comb begin
    s_nxt      = s_r;
    s_nxt.pack = '0;
    if (awvalid && awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.awa   = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wd   = wdata;
      s_nxt.ws   = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (wr_hit) begin
        case (woff)
          OFF_MAR:  s_nxt.mem_pointer[wch] = wv;
          OFF_PSR:  s_nxt.peripheral_identifier[wch] = wv[PID_W-1:0];
          OFF_TCR:  s_nxt.item_count[wch] = wv[CNT_W-1:0];
          OFF_MEM_POINTER_RELOAD: s_nxt.mem_pointer_reload[wch] = wv;
          OFF_ITEM_COUNT_RELOAD: s_nxt.item_count_reload[wch] = wv[CNT_W-1:0];
          OFF_MODE: s_nxt.size[wch] = wv[SIZE_W-1:0];
          OFF_CMD: begin
            if (wd_m[BIT_EN]) s_nxt.en[wch] = 1'b1;
            // Disable wins when both command bits are written together.
            if (wd_m[BIT_DIS]) s_nxt.en[wch] = 1'b0;
            if (wd_m[BIT_ERROR_CLEAR_CMD]) s_nxt.err[wch] = 1'b0;
          end
          default: ;
        endcase
      end
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = ar_hit ? rd_word(ach, aoff) : '0;
      s_nxt.rresp  = ar_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // The engine runs after software writes, so it wins a same-cycle clash.
    case (s_r.xf)
      XF_IDLE: begin
        if (arb.gnt_valid) begin
          s_nxt.xf  = XF_MEM;
          s_nxt.cur = arb.gnt_idx;
          s_nxt.ma  = s_r.mem_pointer[arb.gnt_idx];
          s_nxt.ms  = s_r.size[arb.gnt_idx];
          s_nxt.mp  = s_r.peripheral_identifier[arb.gnt_idx];
        end
      end
      XF_MEM: begin
        if (mem_ack) begin
          s_nxt.xf = XF_IDLE;
          if (mem_err) begin
            s_nxt.err[s_r.cur] = 1'b1;
          end else begin
            s_nxt.mem_pointer[s_r.cur]  = s_r.mem_pointer[s_r.cur] + stp;
            s_nxt.item_count[s_r.cur]  = s_r.item_count[s_r.cur] - 16'h1;
            s_nxt.pack[s_r.cur] = 1'b1;
          end
        end
      end
      default: s_nxt.xf = XF_IDLE;
    endcase
    for (int i = 0; i < N_CH; i++) begin
      if (s_r.en[i] && (s_r.size[i] == SIZE_RSVD)) begin
        s_nxt.err[i] = 1'b1;
      end
      if ((s_nxt.item_count[i] == '0) && (s_nxt.item_count_reload[i] != '0)) begin
        s_nxt.mem_pointer[i]  = s_nxt.mem_pointer_reload[i];
        s_nxt.item_count[i]  = s_nxt.item_count_reload[i];
        s_nxt.item_count_reload[i] = '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r    <= '0;
      s_r.xf <= XF_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign rvalid     = s_r.rvalid;
  assign rdata      = s_r.rdata;
  assign rresp      = s_r.rresp;
  assign periph_ack = s_r.pack;
  assign mem_req    = (s_r.xf == XF_MEM);
  assign mem_addr   = s_r.ma;
  assign mem_size   = s_r.ms;
  assign mem_pid    = s_r.mp;

  sequence s_item0;
    (s_r.xf == XF_MEM) && mem_ack && !mem_err && (s_r.cur == '0);
  endsequence

  sequence s_fail0;
    (s_r.xf == XF_MEM) && mem_ack && mem_err && (s_r.cur == '0);
  endsequence

  property p_ptr_step;
    @(posedge aclk) disable iff (!aresetn)
      s_item0 ##0 (s_r.item_count[0] > 16'h1)
        |=> s_r.mem_pointer[0] == $past(s_r.mem_pointer[0]) + $past(stp);
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("Pointer did not advance by the item size.");

  property p_count_dec;
    @(posedge aclk) disable iff (!aresetn)
      s_item0 ##0 (s_r.item_count[0] > 16'h1)
        |=> s_r.item_count[0] == $past(s_r.item_count[0]) - 16'h1;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("Item count did not drop by one.");

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      s_item0 ##0 (s_r.item_count[0] == 16'h1) && (s_r.item_count_reload[0] != '0) && !wr_go
        |=> (s_r.item_count[0] == $past(s_r.item_count_reload[0])) && (s_r.item_count_reload[0] == '0)
            && (s_r.mem_pointer[0] == $past(s_r.mem_pointer_reload[0]));
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload pair was not taken when the count ran out.");

  property p_start_ok;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.xf == XF_IDLE) && arb.gnt_valid
        |-> (s_r.item_count[arb.gnt_idx] != '0) && s_r.en[arb.gnt_idx]
            && !s_r.err[arb.gnt_idx]
            && (s_r.size[arb.gnt_idx] != SIZE_RSVD)
            ##1 mem_req;
  endproperty
  a_start_ok: assert property (p_start_ok)
    else $error("A transfer started on an ineligible channel.");

  property p_err_set;
    @(posedge aclk) disable iff (!aresetn)
      s_fail0 |=> s_r.err[0] && !mem_req ##1 !(mem_req && s_r.cur == '0)
                  || !s_r.err[0];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("Failed access did not stop the channel.");

  property p_err_sticky;
    @(posedge aclk) disable iff (!aresetn)
      s_r.err[0] && !(wr_go && wr_hit && (wch == '0) && (woff == OFF_CMD)
                      && wd_m[BIT_ERROR_CLEAR_CMD])
        |=> s_r.err[0];
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("Error flag dropped without a clear command.");

  property p_enable;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && wr_hit && (wch == '0) && (woff == OFF_CMD)
        && wd_m[BIT_EN] && !wd_m[BIT_DIS]
        |=> s_r.en[0] ##1 (s_r.en[0] || $past(wr_go));
  endproperty
  a_enable: assert property (p_enable)
    else $error("Enable command did not enable the channel.");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
      arvalid && arready |=> rvalid [*1] ##0 !arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read was not answered on the next cycle.");

endmodule : dma_channel_regs

// *** dma_irq_unit.sv ***
// Interrupt mask, status view and request for one DMA channel.
// Assumes set and clear strobes are one-cycle pulses from the register file.
`timescale 1ns/1ps
module dma_irq_unit (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [dma_pkg::NSRC-1:0]  en_set,
  input  wire logic [dma_pkg::NSRC-1:0]  en_clr,
  input  wire logic                      err,
  input  wire logic                      cnt_zero,
  input  wire logic                      rld_zero,
  output logic      [dma_pkg::NSRC-1:0]  mask,
  output logic      [dma_pkg::NSRC-1:0]  status,
  output logic                           irq
);
  import dma_pkg::*;

  typedef struct packed {
    logic [NSRC-1:0] mask;
  } irq_st_t;

  irq_st_t s_r;
  irq_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    // A set in the same cycle as a clear leaves the source enabled.
    s_nxt.mask = (s_r.mask & ~en_clr) | en_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    status           = '0;
    status[BIT_TRANSFER_ERROR_FLAG] = err;
    status[BIT_TRC]  = cnt_zero && rld_zero;
    status[BIT_RCZ]  = rld_zero;
  end

  assign mask = s_r.mask;
  assign irq  = |(status & s_r.mask);

  property p_mask_set;
    @(posedge aclk) disable iff (!aresetn)
      en_set[BIT_TRC] |=> mask[BIT_TRC];
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("Mask bit did not set after an enable write.");

  property p_mask_clr;
    @(posedge aclk) disable iff (!aresetn)
      en_clr[BIT_TRANSFER_ERROR_FLAG] && !en_set[BIT_TRANSFER_ERROR_FLAG] |=> !mask[BIT_TRANSFER_ERROR_FLAG];
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("Mask bit did not clear after a disable write.");

endmodule : dma_irq_unit

// *** dma_mem_model.sv ***
// Behavioural memory port that answers the DMA engine's item requests.
// Assumes one clock; each held request is acknowledged lat+1 cycles after it is raised.
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  lat,
  output logic             mem_ack,
  output logic             mem_err
);
  logic [3:0] cnt_r;

  // The top sixteenth of the address space fails, so errors can be provoked.
  // Between answers the error line toggles so that a stale value is never
  // mistaken for a real one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      cnt_r   <= 4'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_err <= ~mem_err;
      cnt_r   <= 4'h0;
    end else if (cnt_r >= lat) begin
      mem_ack <= 1'b1;
      mem_err <= (mem_addr[31:28] == 4'hf);
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : dma_mem_model

// *** dma_pkg.sv ***
// Shared constants for the peripheral DMA channel register block.
// Assumes a 32-bit AXI4-Lite register bus and a 64-byte register stride.
package dma_pkg;

  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int CH_STRIDE_LSB = 6;

  localparam logic [5:0] OFF_MAR  = 6'h00;
  localparam logic [5:0] OFF_PSR  = 6'h04;
  localparam logic [5:0] OFF_TCR  = 6'h08;
  localparam logic [5:0] OFF_MEM_POINTER_RELOAD = 6'h0c;
  localparam logic [5:0] OFF_ITEM_COUNT_RELOAD = 6'h10;
  localparam logic [5:0] OFF_CMD  = 6'h14;
  localparam logic [5:0] OFF_MODE = 6'h18;
  localparam logic [5:0] OFF_STAT = 6'h1c;
  localparam logic [5:0] OFF_IER  = 6'h20;
  localparam logic [5:0] OFF_IDR  = 6'h24;
  localparam logic [5:0] OFF_IMR  = 6'h28;
  localparam logic [5:0] OFF_ISR  = 6'h2c;

  localparam int CNT_W = 16;
  localparam int SIZE_W = 2;
  localparam int NSRC = 3;

  localparam int BIT_EN   = 0;
  localparam int BIT_DIS  = 1;
  localparam int BIT_ERROR_CLEAR_CMD = 8;

  localparam int BIT_RCZ  = 0;
  localparam int BIT_TRC  = 1;
  localparam int BIT_TRANSFER_ERROR_FLAG = 2;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;

  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] STEP_WORD = 32'h0000_0004;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    XF_IDLE = 2'h0,
    XF_MEM  = 2'h1
  } xf_state_t;

endpackage : dma_pkg

// *** dma_prio_arbiter.sv ***
// Fixed-priority channel arbiter for the DMA engine.
// Assumes requests are already qualified; the lowest index always wins.
`timescale 1ns/1ps
module dma_prio_arbiter #(
  parameter int N  = 2,
  parameter int CW = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  dma_arb_if.arbiter a
);
  import dma_pkg::*;

  always_comb begin
    a.gnt_valid = 1'b0;
    a.gnt_idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (a.req[i]) begin
        a.gnt_valid = 1'b1;
        a.gnt_idx   = CW'(i);
      end
    end
  end

  property p_prio_low;
    @(posedge aclk) disable iff (!aresetn)
      a.req[0] |-> a.gnt_valid && (a.gnt_idx == '0);
  endproperty
  a_prio_low: assert property (p_prio_low)
    else $error("Channel 0 request was not granted first.");

endmodule : dma_prio_arbiter

// *** peripheral_dma_channel_regs_tb.sv ***
// Self-checking bench for the DMA channel registers and transfer engine.
// Assumes the memory model beside it and the design's two channels.
`timescale 1ns/1ps
module peripheral_dma_channel_regs_tb;
  import dma_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, mem_req;
  logic        mem_ack, mem_err;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, v;
  logic [3:0]  wstrb, lat;
  logic [1:0]  bresp, rresp, mem_size, periph_req, periph_ack, chan_irq, r;
  logic [4:0]  mem_pid;
  logic [44:0] rows [35];
  logic [38:0] aq [$];
  logic [38:0] e0 [3];
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  int          nack = 0;
  int          k;

  dma_channel_regs dma_channel_regs_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .periph_req, .periph_ack, .mem_req, .mem_addr,
    .mem_size, .mem_pid, .mem_ack, .mem_err, .chan_irq);
  dma_mem_model dma_mem_model_inst (
    .aclk, .aresetn, .mem_req, .mem_addr, .lat, .mem_ack, .mem_err);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    nack <= nack + $countones(periph_ack);
    if (mem_req && mem_ack) aq.push_back({mem_pid, mem_size, mem_addr});
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [39:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Ready is sampled at the falling edge, so it is the value the next
  // rising edge will see; every request is then changed at that edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hr, hb;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hr = arvalid & arready;
      hb = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      v = rdata;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hr) arvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      if (hb) rready <= 1'b0;
    end
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), v, e);
  endtask : rd

  // The extra cycles show that no further item starts.
  task automatic wait_items(input int n);
    while (aq.size() < n) @(posedge aclk);
    repeat (20) @(posedge aclk);
    chk("items", 40'(aq.size()), 40'(n));
  endtask : wait_items

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, periph_req, lat} = 62'h0;
    wstrb = 4'hf;
    rows = '{
      {1'h0, 12'h000, 32'h0},
      {1'h0, 12'h01c, 32'h0},
      {1'h0, 12'h028, 32'h0},
      {1'h0, 12'h02c, 32'h3},
      {1'h1, 12'h004, 32'hffffffff},
      {1'h0, 12'h004, 32'h1f},
      {1'h1, 12'h008, 32'hffffffff},
      {1'h0, 12'h008, 32'hffff},
      {1'h0, 12'h02c, 32'h1},
      {1'h1, 12'h010, 32'h5},
      {1'h0, 12'h02c, 32'h0},
      {1'h1, 12'h00c, 32'h40},
      {1'h1, 12'h008, 32'h0},
      {1'h0, 12'h008, 32'h5},
      {1'h0, 12'h000, 32'h40},
      {1'h0, 12'h010, 32'h0},
      {1'h1, 12'h018, 32'hffffffff},
      {1'h0, 12'h018, 32'h3},
      {1'h1, 12'h020, 32'h7},
      {1'h1, 12'h024, 32'h2},
      {1'h1, 12'h024, 32'h0},
      {1'h0, 12'h028, 32'h5},
      {1'h1, 12'h01c, 32'h1},
      {1'h1, 12'h014, 32'h0},
      {1'h0, 12'h01c, 32'h0},
      {1'h0, 12'h030, 32'h0},
      {1'h1, 12'h080, 32'h1},
      {1'h1, 12'h014, 32'h1},
      {1'h0, 12'h01c, 32'h1},
      {1'h0, 12'h02c, 32'h5},
      {1'h1, 12'h014, 32'h2},
      {1'h0, 12'h01c, 32'h0},
      {1'h1, 12'h018, 32'h1},
      {1'h1, 12'h014, 32'h100},
      {1'h0, 12'h02c, 32'h1}
    };
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i][44], rows[i][43:32], rows[i][31:0]);
      chk("resp", r, (rows[i][37:32] > OFF_ISR || rows[i][43:38] > 6'h1)
          ? RESP_SLVERR : RESP_OKAY);
      if (!rows[i][44]) chk("read", v, rows[i][31:0]);
    end
    chk("irq", chan_irq, 2'h1);
    bus(1'b1, 12'h004, 32'h3);
    bus(1'b1, 12'h00c, 32'h800);
    bus(1'b1, 12'h010, 32'h1);
    bus(1'b1, 12'h008, 32'h2);
    bus(1'b1, 12'h000, 32'h100);
    bus(1'b1, 12'h044, 32'h9);
    bus(1'b1, 12'h058, 32'h2);
    bus(1'b1, 12'h040, 32'h200);
    bus(1'b1, 12'h048, 32'h1);
    bus(1'b1, 12'h054, 32'h1);
    bus(1'b1, 12'h014, 32'h1);
    periph_req <= 2'h3;
    wait_items(4);
    chk("first", aq[0][38:34], 5'h3);
    e0 = '{{5'h3, SIZE_HALF, 32'h100}, {5'h3, SIZE_HALF, 32'h102},
           {5'h3, SIZE_HALF, 32'h800}};
    k = 0;
    foreach (aq[i]) begin
      if (aq[i][38:34] === 5'h3) chk("ch0", aq[i], e0[k++]);
      else chk("ch1", aq[i], {5'h9, SIZE_WORD, 32'h200});
    end
    rd(12'h000, 32'h802);
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h02c, 32'h3);
    rd(12'h040, 32'h204);
    lat <= 4'h3;
    bus(1'b1, 12'h058, 32'h0);
    bus(1'b1, 12'h040, 32'h300);
    bus(1'b1, 12'h048, 32'h2);
    wait_items(6);
    chk("byte", aq[5], {5'h9, SIZE_BYTE, 32'h301});
    rd(12'h040, 32'h302);
    chk("acks", nack, 40'h6);
    bus(1'b1, 12'h000, 32'hf0000000);
    bus(1'b1, 12'h008, 32'h3);
    wait_items(7);
    rd(12'h02c, 32'h5);
    rd(12'h000, 32'hf0000000);
    rd(12'h008, 32'h3);
    chk("acks", nack, 40'h6);
    chk("irq", chan_irq[0], 1'h1);
    bus(1'b1, 12'h000, 32'h400);
    bus(1'b1, 12'h014, 32'h100);
    wait_items(10);
    rd(12'h000, 32'h406);
    rd(12'h02c, 32'h3);
    chk("acks", nack, 40'h9);
    complete_run();
  end
endmodule : peripheral_dma_channel_regs_tb
